//--- sas_pkg.sv
// Constants and types for the converter sequencer.
// Assumes one clock edge per machine cycle.
package sas_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX     = 8'hc5;
    localparam logic [7:0] RESHI_IDX    = 8'hc6;
    localparam logic [7:0] AUX_IDX      = 8'hc7;
    localparam logic [7:0] PWR_IDX      = 8'hc8;

    // Converter control field positions
    localparam int CTRL_RES1_BIT  = 7;
    localparam int CTRL_RES0_BIT  = 6;
    localparam int CTRL_EXTEN_BIT = 5;
    localparam int CTRL_DONE_BIT  = 4;
    localparam int CTRL_START_BIT = 3;
    localparam int CTRL_CHAN_LSB  = 0;
    // Auxiliary control field positions
    localparam int AUX_EIGHT_BIT  = 7;
    localparam int AUX_IDLEOP_BIT = 6;
    // Power mode field positions
    localparam int PWR_IDLE_BIT   = 0;
    localparam int PWR_PDOWN_BIT  = 1;

    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Sequence timing in machine cycles
    localparam int INIT_CYC    = 2;
    localparam int SAMP10_CYC  = 8;
    localparam int TRIAL10_CYC = 4;
    localparam int BITS10      = 10;
    localparam int SAMP8_CYC   = 6;
    localparam int TRIAL8_CYC  = 2;
    localparam int BITS8       = 8;
    localparam int TOTAL10 = INIT_CYC + SAMP10_CYC + BITS10 * TRIAL10_CYC;
    localparam int TOTAL8  = INIT_CYC + SAMP8_CYC + BITS8 * TRIAL8_CYC;

    localparam logic [9:0] SAR_FIRST = 10'h200;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } sas_conv_t;

endpackage : sas_pkg

//--- sas_adc_sequencer.sv
// Successive approximation converter sequencer with AXI4-Lite registers.
// Assumes comparator and start pin synchronous to CLK_IN, one edge per
// machine cycle.
`timescale 1ns/1ps

// Operation
// - Eight-channel mux, ten-bit successive approximation
// - Eight-bit mode runs 24 cycles
// - Ten-bit conversion takes 50 cycles
// - Idle enable keeps converter alive in idle
// - External disabled: software start only
// - External enabled: software or rising pin edge
// - Pin edge seen, conversion starts next cycle
// - Software start begins next machine cycle
// - Start command and status are separate flops
// - Two init cycles; status set after first
// - Sample selected channel eight cycles, six in eight-bit mode
// - Load top bit, test bits downward
// - Four cycles per bit trial, two in eight-bit mode
// - Done sets, result to high byte, bits 7:6
// - Command and status clear after 50/24
// - Control bits 2:0 drive the mux
// - Running conversion ignores new starts
// - Result frozen while done flag set
// - Power-down, or idle without idle enable, aborts running conversion
module sas_adc_sequencer #(
    parameter int AW = 12
) (
    input  wire logic          CLK_IN,
    input  wire logic          RST_IN,
    input  wire logic [AW-1:0] S_AXI_AWADDR_IN,
    input  wire logic          S_AXI_AWVALID_IN,
    output      logic          S_AXI_AWREADY_OUT,
    input  wire logic [31:0]   S_AXI_WDATA_IN,
    input  wire logic [3:0]    S_AXI_WSTRB_IN,
    input  wire logic          S_AXI_WVALID_IN,
    output      logic          S_AXI_WREADY_OUT,
    output      logic [1:0]    S_AXI_BRESP_OUT,
    output      logic          S_AXI_BVALID_OUT,
    input  wire logic          S_AXI_BREADY_IN,
    input  wire logic [AW-1:0] S_AXI_ARADDR_IN,
    input  wire logic          S_AXI_ARVALID_IN,
    output      logic          S_AXI_ARREADY_OUT,
    output      logic [31:0]   S_AXI_RDATA_OUT,
    output      logic [1:0]    S_AXI_RRESP_OUT,
    output      logic          S_AXI_RVALID_OUT,
    input  wire logic          S_AXI_RREADY_IN,
    input  wire logic          EXT_START_IN,
    input  wire logic          CMP_IN,
    output      logic [2:0]    CHAN_SEL_OUT,
    output      logic [9:0]    LADDER_CODE_OUT,
    output      logic          SAMPLE_OUT,
    output      logic          ANALOG_ON_OUT
);

    typedef struct packed {
        sas_pkg::sas_conv_t st;
        logic [5:0]         cyc;
        logic               cmd;
        logic               status;
        logic               done;
        logic               mode8;
        logic [9:0]         sar;
        logic [9:0]         ptr;
        logic [9:0]         res;
        logic               ext_en;
        logic [2:0]         chan;
        logic               aux8;
        logic               auxidl;
        logic               idle;
        logic               pdown;
        logic               ext_prev;
        logic               aw_got;
        logic [AW-1:0]      awaddr;
        logic               w_got;
        logic [7:0]         wdata;
        logic               wlane0;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } sas_state_t;

    sas_state_t s_r;
    sas_state_t s_nxt;

    logic          aw_take;
    logic          w_take;
    logic          wr_go;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    logic          wr_lane;
    logic          sw_start;
    logic          done_clr;
    logic          ext_rise;
    logic          start_req;
    logic          go;
    logic          off;
    logic [5:0]    last_cyc;
    logic [5:0]    load_cyc;
    logic [5:0]    first_dec;
    logic [5:0]    dec_off;
    logic [5:0]    dec_msk;
    logic          dec;
    logic [9:0]    sar_dec;
    logic [7:0]    ctrl_rd;

    function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
        hit = (a[AW-1:2] == (AW-2)'(idx)) && (a[1:0] == 2'h0);
    endfunction : hit

    function automatic logic mapped(input logic [AW-1:0] a);
        mapped = hit(a, sas_pkg::CTRL_IDX) || hit(a, sas_pkg::RESHI_IDX)
              || hit(a, sas_pkg::AUX_IDX) || hit(a, sas_pkg::PWR_IDX);
    endfunction : mapped

    assign S_AXI_AWREADY_OUT = !s_r.aw_got && !s_r.bvalid;
    assign S_AXI_WREADY_OUT  = !s_r.w_got && !s_r.bvalid;
    assign S_AXI_ARREADY_OUT = !s_r.rvalid;
    assign S_AXI_BVALID_OUT  = s_r.bvalid;
    assign S_AXI_BRESP_OUT   = s_r.bresp;
    assign S_AXI_RVALID_OUT  = s_r.rvalid;
    assign S_AXI_RDATA_OUT   = s_r.rdata;
    assign S_AXI_RRESP_OUT   = s_r.rresp;
    assign CHAN_SEL_OUT      = s_r.chan;
    assign LADDER_CODE_OUT   = s_r.sar;
    // powered off in idle unless enabled
    assign off               = s_r.pdown || (s_r.idle && !s_r.auxidl);
    assign ANALOG_ON_OUT     = !off;
    assign SAMPLE_OUT = (s_r.st == sas_pkg::ST_CONV)
                     && (s_r.cyc >= 6'(sas_pkg::INIT_CYC)) && (s_r.cyc <= load_cyc);

    assign last_cyc  = s_r.mode8 ? 6'(sas_pkg::TOTAL8 - 1) : 6'(sas_pkg::TOTAL10 - 1);
    assign load_cyc  = s_r.mode8 ? 6'(sas_pkg::INIT_CYC + sas_pkg::SAMP8_CYC - 1)
                                 : 6'(sas_pkg::INIT_CYC + sas_pkg::SAMP10_CYC - 1);
    assign first_dec = s_r.mode8 ? 6'(sas_pkg::INIT_CYC + sas_pkg::SAMP8_CYC
                                      + sas_pkg::TRIAL8_CYC - 1)
                                 : 6'(sas_pkg::INIT_CYC + sas_pkg::SAMP10_CYC
                                      + sas_pkg::TRIAL10_CYC - 1);
    assign dec_msk   = s_r.mode8 ? 6'(sas_pkg::TRIAL8_CYC - 1)
                                 : 6'(sas_pkg::TRIAL10_CYC - 1);
    assign dec_off   = s_r.cyc - first_dec;
    assign dec       = (s_r.cyc >= first_dec) && ((dec_off & dec_msk) == 6'h00);
    // keep bit when input above ladder, set next
    assign sar_dec   = (CMP_IN ? s_r.sar : (s_r.sar & ~s_r.ptr)) | (s_r.ptr >> 1);

    assign ctrl_rd = {s_r.res[1:0], s_r.ext_en, s_r.done, s_r.status, s_r.chan};

    always_comb begin
        s_nxt     = s_r;
        aw_take   = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
        w_take    = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
        wr_addr   = s_r.aw_got ? s_r.awaddr : S_AXI_AWADDR_IN;
        wr_data   = s_r.w_got ? s_r.wdata : S_AXI_WDATA_IN[7:0];
        wr_lane   = s_r.w_got ? s_r.wlane0 : S_AXI_WSTRB_IN[0];
        wr_go     = (s_r.aw_got || aw_take) && (s_r.w_got || w_take) && !s_r.bvalid;
        sw_start  = 1'b0;
        done_clr  = 1'b0;
        if (aw_take) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = S_AXI_AWADDR_IN;
        end
        if (w_take) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.wdata  = S_AXI_WDATA_IN[7:0];
            s_nxt.wlane0 = S_AXI_WSTRB_IN[0];
        end
        if (s_r.bvalid && S_AXI_BREADY_IN) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = mapped(wr_addr) ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
            if (wr_lane && hit(wr_addr, sas_pkg::CTRL_IDX)) begin
                s_nxt.ext_en = wr_data[sas_pkg::CTRL_EXTEN_BIT];
                s_nxt.chan   = wr_data[sas_pkg::CTRL_CHAN_LSB +: 3];
                // software start sets the command flop
                sw_start     = wr_data[sas_pkg::CTRL_START_BIT];
                // zero written to done clears it
                done_clr     = !wr_data[sas_pkg::CTRL_DONE_BIT];
            end
            if (wr_lane && hit(wr_addr, sas_pkg::AUX_IDX)) begin
                s_nxt.aux8   = wr_data[sas_pkg::AUX_EIGHT_BIT];
                s_nxt.auxidl = wr_data[sas_pkg::AUX_IDLEOP_BIT];
            end
            if (wr_lane && hit(wr_addr, sas_pkg::PWR_IDX)) begin
                s_nxt.idle   = wr_data[sas_pkg::PWR_IDLE_BIT];
                s_nxt.pdown  = wr_data[sas_pkg::PWR_PDOWN_BIT];
            end
        end

        // rising pin edge caught at the cycle end
        s_nxt.ext_prev = EXT_START_IN;
        ext_rise  = EXT_START_IN && !s_r.ext_prev;
        start_req = sw_start || (s_r.ext_en && ext_rise);
        // start only when free and not done
        go        = start_req && (s_r.st == sas_pkg::ST_IDLE) && !s_r.done && !off;

        if (done_clr) begin
            s_nxt.done = 1'b0;
        end

        case (s_r.st)
            sas_pkg::ST_IDLE: begin
                if (go) begin
                    // command flop set apart from status
                    s_nxt.st    = sas_pkg::ST_CONV;
                    s_nxt.cyc   = 6'h00;
                    s_nxt.cmd   = 1'b1;
                    s_nxt.mode8 = s_r.aux8;
                end
            end
            sas_pkg::ST_CONV: begin
                if (off) begin
                    s_nxt.st     = sas_pkg::ST_IDLE;
                    s_nxt.cmd    = 1'b0;
                    s_nxt.status = 1'b0;
                end else begin
                    s_nxt.cyc = s_r.cyc + 6'h01;
                    // status set after first init cycle
                    if (s_r.cyc == 6'h00) begin
                        s_nxt.status = 1'b1;
                    end
                    if (s_r.cyc == load_cyc) begin
                        s_nxt.sar = sas_pkg::SAR_FIRST;
                        s_nxt.ptr = sas_pkg::SAR_FIRST;
                    end
                    if (dec) begin
                        s_nxt.sar = sar_dec;
                        s_nxt.ptr = s_r.ptr >> 1;
                    end
                    if (s_r.cyc == last_cyc) begin
                        s_nxt.st     = sas_pkg::ST_IDLE;
                        s_nxt.cmd    = 1'b0;
                        s_nxt.status = 1'b0;
                        s_nxt.done   = 1'b1;
                        s_nxt.res    = s_r.mode8 ? {sar_dec[9:2], 2'b00} : sar_dec;
                    end
                end
            end
            default: begin
                s_nxt.st = sas_pkg::ST_IDLE;
            end
        endcase

        if (s_r.rvalid && S_AXI_RREADY_IN) begin
            s_nxt.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = mapped(S_AXI_ARADDR_IN) ? sas_pkg::RESP_OKAY
                                                   : sas_pkg::RESP_SLVERR;
            s_nxt.rdata  = 32'h0000_0000;
            if (hit(S_AXI_ARADDR_IN, sas_pkg::CTRL_IDX)) begin
                s_nxt.rdata = {24'h00_0000, ctrl_rd};
            end
            if (hit(S_AXI_ARADDR_IN, sas_pkg::RESHI_IDX)) begin
                s_nxt.rdata = {24'h00_0000, s_r.res[9:2]};
            end
            if (hit(S_AXI_ARADDR_IN, sas_pkg::AUX_IDX)) begin
                s_nxt.rdata = {24'h00_0000, s_r.aux8, s_r.auxidl, 6'h00};
            end
            if (hit(S_AXI_ARADDR_IN, sas_pkg::PWR_IDX)) begin
                s_nxt.rdata = {24'h00_0000, 6'h00, s_r.pdown, s_r.idle};
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            s_r    <= '0;
            s_r.st <= sas_pkg::ST_IDLE;
        end else begin
            s_r    <= s_nxt;
        end
    end

    // Checks
    sequence s_go;
        go;
    endsequence

    sequence s_init;
        !s_r.status ##1 s_r.status;
    endsequence

    property p_status_init;
        @(posedge CLK_IN) disable iff (RST_IN || off)
        s_go |-> ##1 s_init;
    endproperty
    a_status_init: assert property (p_status_init)
        else $error("status flag not set after first cycle");

    property p_ten_time;
        @(posedge CLK_IN) disable iff (RST_IN)
        $rose(s_r.done) && !s_r.mode8 |-> $past(s_r.cyc) == 6'd49;
    endproperty
    a_ten_time: assert property (p_ten_time)
        else $error("ten-bit done not at 50 cycles");

    property p_eight_time;
        @(posedge CLK_IN) disable iff (RST_IN)
        $rose(s_r.done) && s_r.mode8 |-> $past(s_r.cyc) == 6'd23;
    endproperty
    a_eight_time: assert property (p_eight_time)
        else $error("eight-bit done not at 24 cycles");

    property p_done_status;
        @(posedge CLK_IN) disable iff (RST_IN)
        $rose(s_r.done) |-> !s_r.status && !s_r.cmd && (s_r.st == sas_pkg::ST_IDLE);
    endproperty
    a_done_status: assert property (p_done_status)
        else $error("status not cleared with done");

    property p_sar_load;
        @(posedge CLK_IN) disable iff (RST_IN || off)
        (s_r.st == sas_pkg::ST_CONV) && (s_r.cyc == load_cyc) |=> s_r.sar == 10'h200;
    endproperty
    a_sar_load: assert property (p_sar_load)
        else $error("approximation not loaded with top bit");

    property p_busy_ignores;
        @(posedge CLK_IN) disable iff (RST_IN || off)
        (s_r.st == sas_pkg::ST_CONV) && start_req && (s_r.cyc != last_cyc)
        |=> s_r.cyc == $past(s_r.cyc) + 6'h01;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores)
        else $error("running conversion disturbed by start");

    property p_result_hold;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_r.done && $past(s_r.done) |-> $stable(s_r.res);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed while done set");

    property p_abort;
        @(posedge CLK_IN) disable iff (RST_IN)
        (s_r.st == sas_pkg::ST_CONV) && off |=> (s_r.st == sas_pkg::ST_IDLE) && !s_r.status;
    endproperty
    a_abort: assert property (p_abort)
        else $error("conversion not aborted on power mode");

    property p_done_blocks;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_r.done && (s_r.st == sas_pkg::ST_IDLE) |=> s_r.st == sas_pkg::ST_IDLE;
    endproperty
    a_done_blocks: assert property (p_done_blocks)
        else $error("start accepted while done set");

    property p_done_sticky;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_r.done && !done_clr |=> s_r.done;
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("done cleared without software");

    property p_sw_only;
        @(posedge CLK_IN) disable iff (RST_IN)
        !s_r.ext_en && !sw_start && (s_r.st == sas_pkg::ST_IDLE)
        |=> s_r.st == sas_pkg::ST_IDLE;
    endproperty
    a_sw_only: assert property (p_sw_only)
        else $error("start without software when pin disabled");

    property p_pin_start;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_r.ext_en && ext_rise && !s_r.done && !off && (s_r.st == sas_pkg::ST_IDLE)
        |=> (s_r.st == sas_pkg::ST_CONV) && (s_r.cyc == 6'h00) ##2 SAMPLE_OUT;
    endproperty
    a_pin_start: assert property (p_pin_start)
        else $error("pin edge did not start conversion");

    property p_trial_gap;
        @(posedge CLK_IN) disable iff (RST_IN || off)
        (s_r.st == sas_pkg::ST_CONV) && dec && !s_r.mode8 && (s_r.cyc != last_cyc)
        |=> !dec [*3] ##1 dec;
    endproperty
    a_trial_gap: assert property (p_trial_gap)
        else $error("bit trial not four cycles long");

endmodule : sas_adc_sequencer

//--- sas_analog_model.sv
// Analog side model: eight input levels, sample-and-hold and comparator.
// Assumes levels as 10-bit codes and a ladder code from the sequencer.
`timescale 1ns/1ps

module sas_analog_model (
    input  wire logic            clk_in,
    input  wire logic [2:0]      chan_in,
    input  wire logic [9:0]      ladder_in,
    input  wire logic            sample_in,
    input  wire logic [7:0][9:0] vin_in,
    output      logic            cmp_out
);
    logic [9:0] held_r = 10'h000;

    always_ff @(posedge clk_in) begin
        if (sample_in) begin
            held_r <= vin_in[chan_in];
        end
    end

    assign cmp_out = held_r > ladder_in;
endmodule : sas_analog_model

//--- sar_adc_sequencer_tb_top.sv
// Self-checking bench for the converter sequencer over AXI4-Lite.
// Assumes the analog model on the comparator side, one clock domain.
`timescale 1ns/1ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end

module sar_adc_sequencer_tb_top;
    localparam logic [11:0] A_CTRL = {2'h0, sas_pkg::CTRL_IDX, 2'h0};
    localparam logic [11:0] A_HI   = {2'h0, sas_pkg::RESHI_IDX, 2'h0};
    localparam logic [11:0] A_AUX  = {2'h0, sas_pkg::AUX_IDX, 2'h0};
    localparam logic [11:0] A_PWR  = {2'h0, sas_pkg::PWR_IDX, 2'h0};
    localparam logic [11:0] A_BAD  = 12'h004;

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic [11:0]     awaddr = 12'h000;
    logic [11:0]     araddr = 12'h000;
    logic [31:0]     wdata = 32'h0;
    logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic            arvalid = 1'b0, rready = 1'b0, ext_pin = 1'b0;
    logic            awready, wready, bvalid, arready, rvalid, cmp, sample, aon;
    logic [1:0]      bresp, rresp, resp;
    logic [31:0]     rdata;
    logic [2:0]      chan;
    logic [9:0]      ladder, e;
    logic [7:0]      rd;
    logic [7:0][9:0] vin = '0;
    int              fail_count = 0;
    int              check_count = 0;
    int              samp_cnt = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (sample === 1'b1) samp_cnt++;

    sas_adc_sequencer uut (
        .CLK_IN(clk), .RST_IN(rst),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .EXT_START_IN(ext_pin),
        .CMP_IN(cmp), .CHAN_SEL_OUT(chan), .LADDER_CODE_OUT(ladder),
        .SAMPLE_OUT(sample), .ANALOG_ON_OUT(aon)
    );

    sas_analog_model u_model (
        .clk_in(clk), .chan_in(chan), .ladder_in(ladder), .sample_in(sample),
        .vin_in(vin), .cmp_out(cmp)
    );

    task automatic stop_test;
        $display("Checks %0d, errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        bit ok;
        ok = 0;
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin resp = bresp; bready <= 1'b0; ok = 1; end
        end
        if (!ok) begin fail_count++; stop_test(); end
    endtask : wr

    task automatic rd_reg(input logic [11:0] a);
        int n;
        bit ok;
        ok = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin rd = rdata[7:0]; resp = rresp; rready <= 1'b0; ok = 1; end
        end
        if (!ok) begin fail_count++; stop_test(); end
    endtask : rd_reg

    // Reference successive approximation with strict comparison
    function automatic logic [9:0] sar_exp(input logic [9:0] v, input int nb);
        logic [9:0] r, t;
        r = 10'h000;
        for (int b = 9; b >= 10 - nb; b--) begin
            t = r | (10'h001 << b);
            if (v > t) r = t;
        end
        return r;
    endfunction : sar_exp

    task automatic sw_start(input int ch, input logic ext);
        wr(A_CTRL, {2'b00, ext, 2'b00, ch[2:0]});
        wr(A_CTRL, {2'b00, ext, 2'b01, ch[2:0]});
    endtask : sw_start

    task automatic wait_done(input int ch, input int nb, input int s0);
        int n;
        e = sar_exp(vin[ch], nb);
        n = 0;
        rd = 8'h00;
        while (rd[sas_pkg::CTRL_DONE_BIT] !== 1'b1 && n < 100) begin rd_reg(A_CTRL); n++; end
        if (rd[sas_pkg::CTRL_DONE_BIT] !== 1'b1) begin fail_count++; stop_test(); end
        `CHK(rd[sas_pkg::CTRL_START_BIT], 1'b0)
        `CHK(rd[7:6], e[1:0])
        rd_reg(A_HI);
        `CHK(rd, e[9:2])
        `CHK(chan, 3'(ch))
        `CHK(samp_cnt - s0, (nb == 10) ? 8 : sas_pkg::SAMP8_CYC)
    endtask : wait_done

    task automatic pulse_pin(output int d);
        @(posedge clk);
        ext_pin <= 1'b1;
        d = 0;
        while (sample !== 1'b1 && d < 10) begin @(posedge clk); #1; d++; end
        @(posedge clk);
        ext_pin <= 1'b0;
    endtask : pulse_pin

    initial begin
        #1ms;
        fail_count++;
        stop_test();
    end

    initial begin
        int s0, d;
        void'($urandom(32'h8864));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_reg(A_CTRL);
        `CHK(rd, sas_pkg::CTRL_RESET) // converter_control reset
        `CHK(resp, sas_pkg::RESP_OKAY) // converter_control reset
        rd_reg(A_BAD);
        `CHK(resp, sas_pkg::RESP_SLVERR)
        wr(A_BAD, 8'hff);
        `CHK(resp, sas_pkg::RESP_SLVERR)
        for (int k = 0; k < 8; k++) begin
            vin[k] <= 10'($urandom);
            s0 = samp_cnt;
            sw_start(k, 1'b0);
            #1;
            `CHK(sample, 1'b0)
            @(posedge clk);
            #1;
            `CHK(sample, 1'b1)
            rd_reg(A_CTRL);
            `CHK(rd[sas_pkg::CTRL_START_BIT], 1'b1)
            if (k == 3) wr(A_CTRL, 8'h0b);
            wait_done(k, 10, s0);
            vin[k] <= ~vin[k];
            s0 = samp_cnt;
            wr(A_CTRL, {5'b00011, 3'(k)});
            repeat (30) @(posedge clk);
            `CHK(samp_cnt - s0, 0)
            rd_reg(A_CTRL);
            `CHK(rd[sas_pkg::CTRL_DONE_BIT], 1'b1)
            rd_reg(A_HI);
            `CHK(rd, e[9:2])
        end
        wr(A_AUX, 8'h80);
        vin[5] <= 10'($urandom);
        s0 = samp_cnt;
        sw_start(5, 1'b0);
        wait_done(5, 8, s0);
        wr(A_AUX, 8'h00);
        wr(A_CTRL, 8'h02);
        vin[2] <= 10'($urandom);
        s0 = samp_cnt;
        pulse_pin(d);
        repeat (20) @(posedge clk);
        `CHK(samp_cnt - s0, 0)
        wr(A_CTRL, 8'h22);
        s0 = samp_cnt;
        pulse_pin(d);
        `CHK(d, 3)
        wait_done(2, 10, s0);
        sw_start(1, 1'b0);
        repeat (5) @(posedge clk);
        wr(A_PWR, 8'h01);
        `CHK(aon, 1'b0)
        rd_reg(A_CTRL);
        `CHK(rd[4:3], 2'b00)
        wr(A_PWR, 8'h00);
        wr(A_AUX, 8'h40);
        wr(A_PWR, 8'h01);
        `CHK(aon, 1'b1)
        s0 = samp_cnt;
        sw_start(6, 1'b0);
        wait_done(6, 10, s0);
        wr(A_AUX, 8'h00);
        rd_reg(A_HI);
        `CHK(rd, e[9:2])
        wr(A_PWR, 8'h00);
        sw_start(3, 1'b0);
        repeat (5) @(posedge clk);
        wr(A_PWR, 8'h02);
        `CHK(aon, 1'b0)
        rd_reg(A_CTRL);
        `CHK(rd[4:3], 2'b00)
        wr(A_PWR, 8'h00);
        stop_test();
    end
endmodule : sar_adc_sequencer_tb_top
